//--- common/mcu_decode_defines.vh
// Constants for the instruction decoder: opcode fields, patterns,
// reset values, operation codes and flag positions.
// Assumes 16-bit instruction words and an 8-bit datapath.
`ifndef MCU_DECODE_DEFINES_VH
`define MCU_DECODE_DEFINES_VH

// Instruction word fields
`define NIB_MSB 15
`define NIB_LSB 12
`define BYTE_MSB 15
`define BYTE_LSB 8
`define BIT_IDX_MSB 11
`define BIT_IDX_LSB 9
`define COND_MSB 10
`define COND_LSB 8
`define FAST_BIT 0
`define CALL_FAST_BIT 8
`define DEST_BIT 9
`define ACCESS_BIT 8

// Upper nibble patterns
`define NIB_SKIP_CLEAR 4'hB
`define NIB_SKIP_SET 4'hA
`define NIB_OPERAND 4'hF
`define NIB_CONTROL 4'hE
`define NIB_MOVE_FF 4'hC
`define NIB_LITERAL 4'h0

// Upper byte patterns
`define BYTE_ADD_LIT 8'h0F
`define BYTE_SUB_LIT 8'h08
`define BYTE_AND_LIT 8'h0B
`define BYTE_OR_LIT 8'h09
`define BYTE_XOR_LIT 8'h0A
`define BYTE_LOAD_LIT 8'h0E
`define BYTE_MUL_LIT 8'h0D
`define BYTE_RET_LIT 8'h0C
`define BYTE_JUMP 8'hEF
`define BYTE_BANK 8'h01
`define CALL_HI7 7'h76
`define TWO_WORD_HI6 6'h3B
`define BRANCH_HI5 5'h1C

// Whole-word codes
`define W_SLEEP 16'h0003
`define W_WDT_CLEAR 16'h0004
`define W_PUSH 16'h0005
`define W_POP 16'h0006
`define W_IRET_HI15 15'h0008
`define W_RET_HI15 15'h0009
`define W_TBL_HI13 13'h0001
`define TBL_WRITE_BIT 2

// Status flag positions
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
`define FLAGS_ARITH 5'h1F
`define FLAGS_LOGIC 5'h14
`define FLAGS_NONE 5'h00
`define FLAGS_POWER 5'h00

// Operation codes handed to the datapath
`define OP_NOP 5'h00
`define OP_ADD_LIT 5'h01
`define OP_SUB_LIT 5'h02
`define OP_AND_LIT 5'h03
`define OP_OR_LIT 5'h04
`define OP_XOR_LIT 5'h05
`define OP_LOAD_LIT 5'h06
`define OP_MUL_LIT 5'h07
`define OP_BANK 5'h08
`define OP_RET_LIT 5'h09
`define OP_IRET 5'h0A
`define OP_RETURN 5'h0B
`define OP_SLEEP 5'h0C
`define OP_WDT 5'h0D
`define OP_PUSH 5'h0E
`define OP_POP 5'h0F
`define OP_TBL_RD 5'h10
`define OP_TBL_WR 5'h11
`define OP_BRANCH 5'h12
`define OP_CALL 5'h13
`define OP_JUMP 5'h14
`define OP_BIT_TEST 5'h15
`define OP_FILE 5'h16

// Reset values
`define RST_OP 5'h00
`define RST_BYTE 8'h00
`define RST_TARGET 20'h00000

`endif

//--- rtl/instruction_decode.v
// Instruction decoder and sequencer for the 8-bit core.
// Assumes one program word per cycle on i_instr with i_instr_valid,
// and a datapath that supplies flags and file data in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "mcu_decode_defines.vh"

module instruction_decode
(
   input wire i_ref_clk,
   input wire i_reset_n,
   input wire i_instr_valid,
   input wire [15:0] i_instr,
   input wire [4:0] i_status,
   input wire [7:0] i_file_data,
   input wire i_target_is_port,
   input wire i_target_is_timer0,
   input wire i_prescaler_on_timer0,
   output reg o_op_valid,
   output reg [4:0] o_op_code,
   output reg [7:0] o_literal,
   output reg [4:0] o_flag_mask,
   output reg o_working_register_write,
   output reg o_pc_load,
   output reg [19:0] o_pc_target,
   output reg o_stack_push,
   output reg o_stack_pop,
   output reg o_fast_save,
   output reg o_fast_restore,
   output reg o_irq_enable_set,
   output reg o_sleep,
   output reg o_wdt_clear,
   output reg o_bank_load,
   output reg o_tbl_read,
   output reg o_tbl_write,
   output reg [1:0] o_tbl_ptr_mode,
   output reg o_src_from_pins,
   output reg o_prescaler_clear,
   output reg o_flush
);

////////////////////////////////////////////////////////////////////////
// Sequencer states
localparam [3:0] S_EXEC = 4'h1;
localparam [3:0] S_OPND = 4'h2;
localparam [3:0] S_FLUSH = 4'h4;
localparam [3:0] S_FLUSH2 = 4'h8;

reg [3:0] state_q, state_d;
reg [7:0] hi_addr_q, hi_addr_d;
reg call_q, call_d;
reg fast_q, fast_d;

reg op_valid_d, working_register_write_d, pc_load_d, push_d, pop_d, fsave_d, frest_d;
reg irq_d, sleep_d, wdt_d, bank_d, trd_d, twr_d, pins_d, presc_d, flush_d;
reg [4:0] op_d, mask_d;
reg [7:0] lit_d;
reg [19:0] target_d;
reg [1:0] tmode_d;

wire [3:0] nib = i_instr[`NIB_MSB:`NIB_LSB];
wire [7:0] ubyte = i_instr[`BYTE_MSB:`BYTE_LSB];
wire [7:0] kbyte = i_instr[7:0];
wire two_word = (i_instr[15:10] == `TWO_WORD_HI6) || (nib == `NIB_MOVE_FF);
wire test_bit = i_file_data[i_instr[`BIT_IDX_MSB:`BIT_IDX_LSB]];
wire file_op = (nib >= 4'h1) && (nib <= 4'h9);
wire dest_file = (nib >= 4'h6) || i_instr[`DEST_BIT];
// even codes take on flag set, odd codes on flag clear
wire [3:0] cond_flags = {i_status[`FLAG_N], i_status[`FLAG_OV], i_status[`FLAG_C],
   i_status[`FLAG_Z]};
wire cond_true = cond_flags[i_instr[`COND_MSB:`COND_LSB + 1]] ^ i_instr[`COND_LSB];

////////////////////////////////////////////////////////////////////////
// Decode and sequencing
always @*
begin
   state_d = state_q;
   hi_addr_d = hi_addr_q;
   call_d = call_q;
   fast_d = fast_q;
   op_valid_d = 1'b0;
   op_d = `OP_NOP;
   lit_d = kbyte;
   mask_d = `FLAGS_NONE;
   working_register_write_d = 1'b0;
   pc_load_d = 1'b0;
   target_d = o_pc_target;
   push_d = 1'b0;
   pop_d = 1'b0;
   fsave_d = 1'b0;
   frest_d = 1'b0;
   irq_d = 1'b0;
   sleep_d = 1'b0;
   wdt_d = 1'b0;
   bank_d = 1'b0;
   trd_d = 1'b0;
   twr_d = 1'b0;
   tmode_d = o_tbl_ptr_mode;
   pins_d = 1'b0;
   presc_d = 1'b0;
   flush_d = 1'b0;
   if (i_instr_valid)
   begin
      op_valid_d = 1'b1;
      case (state_q)
         S_OPND:
         begin
            // second word supplies twelve address bits
            state_d = S_EXEC;
            op_d = call_q ? `OP_CALL : `OP_JUMP;
            pc_load_d = 1'b1;
            target_d = {i_instr[11:0], hi_addr_q};
            push_d = call_q;
            fsave_d = call_q & fast_q;
         end
         S_FLUSH:
         begin
            // second cycle runs as a no-op
            flush_d = 1'b1;
            // skipping a two-word instruction costs a third cycle
            state_d = (call_q && two_word) ? S_FLUSH2 : S_EXEC;
         end
         S_FLUSH2:
         begin
            flush_d = 1'b1;
            state_d = S_EXEC;
         end
         default:
         begin
            call_d = 1'b0;
            if (nib == `NIB_SKIP_CLEAR || nib == `NIB_SKIP_SET)
            begin
               // skip on bit clear or set
               op_d = `OP_BIT_TEST;
               pins_d = i_target_is_port;
               if ((nib == `NIB_SKIP_CLEAR) ? !test_bit : test_bit)
               begin
                  state_d = S_FLUSH;
                  call_d = 1'b1;
               end
            end
            else if (nib == `NIB_OPERAND)
               // stray operand word is a no-op
               op_d = `OP_NOP;
            else if (i_instr[15:11] == `BRANCH_HI5)
            begin
               // taken branch adds one flush cycle
               op_d = `OP_BRANCH;
               if (cond_true)
               begin
                  pc_load_d = 1'b1;
                  target_d = {{12{kbyte[7]}}, kbyte};
                  state_d = S_FLUSH;
               end
            end
            else if (i_instr[15:9] == `CALL_HI7 || ubyte == `BYTE_JUMP)
            begin
               // first word holds eight address bits
               op_valid_d = 1'b0;
               hi_addr_d = kbyte;
               call_d = (i_instr[15:9] == `CALL_HI7);
               fast_d = i_instr[`CALL_FAST_BIT];
               state_d = S_OPND;
            end
            else if (file_op)
            begin
               op_d = `OP_FILE;
               pins_d = i_target_is_port;
               presc_d = i_target_is_timer0 & dest_file & i_prescaler_on_timer0;
            end
            else if (ubyte == `BYTE_ADD_LIT || ubyte == `BYTE_SUB_LIT)
            begin
               // add literal or literal minus working register
               op_d = (ubyte == `BYTE_ADD_LIT) ? `OP_ADD_LIT : `OP_SUB_LIT;
               mask_d = `FLAGS_ARITH;
               working_register_write_d = 1'b1;
            end
            else if (ubyte == `BYTE_AND_LIT || ubyte == `BYTE_OR_LIT ||
                     ubyte == `BYTE_XOR_LIT)
            begin
               // logic ops, zero and negative only
               op_d = (ubyte == `BYTE_AND_LIT) ? `OP_AND_LIT :
                      (ubyte == `BYTE_OR_LIT) ? `OP_OR_LIT : `OP_XOR_LIT;
               mask_d = `FLAGS_LOGIC;
               working_register_write_d = 1'b1;
            end
            else if (ubyte == `BYTE_LOAD_LIT)
            begin
               op_d = `OP_LOAD_LIT;
               working_register_write_d = 1'b1;
            end
            else if (ubyte == `BYTE_MUL_LIT)
               op_d = `OP_MUL_LIT;
            else if (ubyte == `BYTE_RET_LIT)
            begin
               op_d = `OP_RET_LIT;
               working_register_write_d = 1'b1;
               pop_d = 1'b1;
               pc_load_d = 1'b1;
               state_d = S_FLUSH;
            end
            else if (ubyte == `BYTE_BANK && i_instr[7:4] == 4'h0)
            begin
               op_d = `OP_BANK;
               bank_d = 1'b1;
               lit_d = {4'h0, i_instr[3:0]};
            end
            else if (i_instr[15:1] == `W_IRET_HI15 || i_instr[15:1] == `W_RET_HI15)
            begin
               // interrupt return sets the single global enable strobe, o_irq_enable_set
               op_d = (i_instr[15:1] == `W_IRET_HI15) ? `OP_IRET : `OP_RETURN;
               irq_d = (i_instr[15:1] == `W_IRET_HI15);
               frest_d = i_instr[`FAST_BIT];
               pop_d = 1'b1;
               pc_load_d = 1'b1;
               state_d = S_FLUSH;
            end
            else if (i_instr[15:3] == `W_TBL_HI13)
            begin
               // table access, pointer mode from low bits
               op_d = i_instr[`TBL_WRITE_BIT] ? `OP_TBL_WR : `OP_TBL_RD;
               trd_d = !i_instr[`TBL_WRITE_BIT];
               twr_d = i_instr[`TBL_WRITE_BIT];
               tmode_d = i_instr[1:0];
               state_d = S_FLUSH;
            end
            else if (i_instr == `W_SLEEP || i_instr == `W_WDT_CLEAR)
            begin
               op_d = (i_instr == `W_SLEEP) ? `OP_SLEEP : `OP_WDT;
               sleep_d = (i_instr == `W_SLEEP);
               wdt_d = (i_instr == `W_WDT_CLEAR);
            end
            else if (i_instr == `W_PUSH || i_instr == `W_POP)
            begin
               // push return address or discard stack top
               op_d = (i_instr == `W_PUSH) ? `OP_PUSH : `OP_POP;
               push_d = (i_instr == `W_PUSH);
               pop_d = (i_instr == `W_POP);
            end
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////
// Registers
always @(posedge i_ref_clk or negedge i_reset_n)
begin
   if (!i_reset_n)
   begin
      state_q <= S_EXEC;
      hi_addr_q <= `RST_BYTE;
      call_q <= 1'b0;
      fast_q <= 1'b0;
      o_op_valid <= 1'b0;
      o_op_code <= `RST_OP;
      o_literal <= `RST_BYTE;
      o_flag_mask <= `FLAGS_NONE;
      o_working_register_write <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_target <= `RST_TARGET;
      o_stack_push <= 1'b0;
      o_stack_pop <= 1'b0;
      o_fast_save <= 1'b0;
      o_fast_restore <= 1'b0;
      o_irq_enable_set <= 1'b0;
      o_sleep <= 1'b0;
      o_wdt_clear <= 1'b0;
      o_bank_load <= 1'b0;
      o_tbl_read <= 1'b0;
      o_tbl_write <= 1'b0;
      o_tbl_ptr_mode <= 2'h0;
      o_src_from_pins <= 1'b0;
      o_prescaler_clear <= 1'b0;
      o_flush <= 1'b0;
   end
   else
   begin
      state_q <= state_d;
      hi_addr_q <= hi_addr_d;
      call_q <= call_d;
      fast_q <= fast_d;
      o_op_valid <= op_valid_d;
      o_op_code <= op_d;
      o_literal <= lit_d;
      o_flag_mask <= mask_d;
      o_working_register_write <= working_register_write_d;
      o_pc_load <= pc_load_d;
      o_pc_target <= target_d;
      o_stack_push <= push_d;
      o_stack_pop <= pop_d;
      o_fast_save <= fsave_d;
      o_fast_restore <= frest_d;
      o_irq_enable_set <= irq_d;
      o_sleep <= sleep_d;
      o_wdt_clear <= wdt_d;
      o_bank_load <= bank_d;
      o_tbl_read <= trd_d;
      o_tbl_write <= twr_d;
      o_tbl_ptr_mode <= tmode_d;
      o_src_from_pins <= pins_d;
      o_prescaler_clear <= presc_d;
      o_flush <= flush_d;
   end
end

endmodule // instruction_decode
`default_nettype wire

//--- verif/instruction_decode_sva.sv
// Checker for the instruction decoder's registered outputs.
// Assumes outputs follow the capturing edge of each valid word.
`timescale 1ns/10ps
`default_nettype none
`include "mcu_decode_defines.vh"
module instruction_decode_sva
(
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [4:0] o_op_code,
   input wire logic [7:0] o_literal,
   input wire logic [4:0] o_flag_mask,
   input wire logic o_working_register_write,
   input wire logic o_pc_load,
   input wire logic [19:0] o_pc_target,
   input wire logic o_stack_pop,
   input wire logic o_fast_restore,
   input wire logic o_irq_enable_set,
   input wire logic o_bank_load,
   input wire logic o_tbl_read,
   input wire logic [1:0] o_tbl_ptr_mode,
   input wire logic o_flush
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);
   // Redirect or table read, then the following word
   sequence s_redirect;
      (o_pc_load && o_op_code != `OP_JUMP && o_op_code != `OP_CALL) || o_tbl_read;
   endsequence
   sequence s_next_word;
      i_instr_valid;
   endsequence
   chk_redirect_flush: assert property (
      s_redirect ##0 s_next_word |=> o_flush && !o_pc_load) else $error("no flush slot");
   chk_add_flags: assert property (
      o_op_code == `OP_ADD_LIT |-> o_flag_mask == 5'h1F && o_working_register_write
      && o_literal == $past(i_instr[7:0])) else $error("add literal wrong");
   chk_sub_flags: assert property (
      o_op_code == `OP_SUB_LIT |-> o_flag_mask == 5'h1F && o_working_register_write
      && $past(i_instr[15:8]) == 8'h08) else $error("subtract literal wrong");
   chk_logic_flags: assert property (
      o_op_code inside {`OP_AND_LIT, `OP_OR_LIT, `OP_XOR_LIT} |-> o_flag_mask == 5'h14
      && o_working_register_write) else $error("logic literal flags wrong");
   chk_load_noflags: assert property (
      o_op_code == `OP_LOAD_LIT |-> o_flag_mask == 5'h00 && o_working_register_write)
      else $error("load literal wrong");
   chk_bank_nibble: assert property (
      o_op_code == `OP_BANK |-> o_bank_load && o_flag_mask == 5'h00
      && o_literal == {4'h0, $past(i_instr[3:0])}) else $error("bank load wrong");
   chk_iret_enables: assert property (
      o_op_code == `OP_IRET |-> o_irq_enable_set && o_stack_pop
      && o_fast_restore == $past(i_instr[0])) else $error("interrupt return wrong");
   chk_table_mode: assert property (
      o_tbl_read |-> o_op_code == `OP_TBL_RD && o_tbl_ptr_mode == $past(i_instr[1:0]))
      else $error("table read mode wrong");
   chk_jump_target: assert property (
      o_op_code == `OP_JUMP |-> o_pc_load && o_pc_target[19:8] == $past(i_instr[11:0]))
      else $error("jump target wrong");
endmodule // instruction_decode_sva
bind instruction_decode instruction_decode_sva i_chk (.i_ref_clk(i_ref_clk),
   .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
   .o_op_code(o_op_code), .o_literal(o_literal), .o_flag_mask(o_flag_mask),
   .o_working_register_write(o_working_register_write), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
   .o_stack_pop(o_stack_pop), .o_fast_restore(o_fast_restore),
   .o_irq_enable_set(o_irq_enable_set), .o_bank_load(o_bank_load),
   .o_tbl_read(o_tbl_read), .o_tbl_ptr_mode(o_tbl_ptr_mode), .o_flush(o_flush));
`default_nettype wire

//--- verif/testbench.sv
// Bench for the instruction decoder: one task per scenario.
// Assumes registered outputs right after the edge taking each word.
`timescale 1ns/10ps
`default_nettype none
`include "mcu_decode_defines.vh"
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic vld = 1'b0;
   logic [15:0] ins = 16'h0000;
   logic [4:0] st = 5'h00;
   logic [7:0] fd = 8'h00;
   logic [2:0] mk = 3'h0;
   wire opv, ww, pcl, psh, pop, fsv, frs, ien, slp, wdc, bnk, trd, twr, pin, pclr, fl;
   wire [4:0] opc, msk;
   wire [7:0] lit;
   wire [19:0] tgt;
   wire [1:0] tpm;
   int err_total = 0;
   int n_compared = 0;
   instruction_decode i_dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_instr_valid(vld),
      .i_instr(ins), .i_status(st), .i_file_data(fd), .i_target_is_port(mk[2]),
      .i_target_is_timer0(mk[1]), .i_prescaler_on_timer0(mk[0]), .o_op_valid(opv),
      .o_op_code(opc), .o_literal(lit), .o_flag_mask(msk), .o_working_register_write(ww),
      .o_pc_load(pcl), .o_pc_target(tgt), .o_stack_push(psh), .o_stack_pop(pop),
      .o_fast_save(fsv), .o_fast_restore(frs), .o_irq_enable_set(ien), .o_sleep(slp),
      .o_wdt_clear(wdc), .o_bank_load(bnk), .o_tbl_read(trd), .o_tbl_write(twr),
      .o_tbl_ptr_mode(tpm), .o_src_from_pins(pin), .o_prescaler_clear(pclr), .o_flush(fl));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("compared %0d, errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   // Words go back to back; outputs judged just after the taking edge
   task automatic go(input logic [15:0] w, input logic [4:0] s = 5'h00,
                     input logic [7:0] f = 8'h00, input logic [2:0] m = 3'h0);
      @(negedge clk);
      ins = w;
      st = s;
      fd = f;
      mk = m;
      vld = 1'b1;
      @(posedge clk);
      #1;
   endtask
   task automatic nxt(input logic f);
      go(16'h0E01);
      chk({fl, ww}, {f, !f});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_literal;
      logic [7:0] b [7] = '{8'h0F, 8'h08, 8'h0B, 8'h09, 8'h0A, 8'h0E, 8'h0D};
      for (int i = 0; i < 7; i++)
      begin
         go({b[i], 8'hA5});
         chk({opv, opc, lit}, {1'b1, 5'(`OP_ADD_LIT + i), 8'hA5});
         chk(msk, i < 2 ? 5'h1F : (i < 5 ? 5'h14 : 5'h00));
         chk(ww, i != 6);
      end
   endtask
   task automatic t_ctrl;
      go(`W_POP);
      chk({pop, psh, msk}, 7'h40);
      go(`W_PUSH);
      chk({pop, psh, msk}, 7'h20);
      go(`W_SLEEP);
      chk({slp, wdc}, 2'h2);
      go(`W_WDT_CLEAR);
      chk({slp, wdc}, 2'h1);
      go(16'h010C);
      chk({bnk, lit}, 9'h10C);
      go(16'hF123);
      chk({opv, fl, pcl, opc}, {3'h4, `OP_NOP});
   endtask
   task automatic t_return;
      go(16'h0011);
      chk({ien, frs, pop}, 3'h7);
      nxt(1'b1);
      go(16'h0C33);
      chk({ww, pop, lit}, 10'h333);
      nxt(1'b1);
      go(16'h0012);
      chk({ien, frs, pop, pcl, opc}, {4'h3, `OP_RETURN});
      nxt(1'b1);
   endtask
   // Reset in mid jump drops the held first word
   task automatic t_reset;
      go(16'hEF12);
      @(negedge clk);
      vld = 1'b0;
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      go(16'hF345);
      chk({opv, pcl, fl}, 3'h4);
   endtask
   task automatic t_table;
      for (int i = 8; i < 16; i++)
      begin
         go(16'(i));
         chk({trd, twr, tpm}, {i < 12, i > 11, 2'(i)});
         nxt(1'b1);
      end
   endtask
   task automatic t_jump;
      go(16'hEF12);
      chk(opv, 1'b0);
      go(16'hF345);
      chk({pcl, opc, tgt}, {1'b1, `OP_JUMP, 20'h34512});
      go(16'h0000);
      go(16'hED9A);
      go(16'hFBCD);
      chk({psh, fsv, opc, tgt}, {2'h3, `OP_CALL, 20'hBCD9A});
      go(16'h0000);
   endtask
   task automatic t_branch;
      int pos [4] = '{`FLAG_Z, `FLAG_C, `FLAG_OV, `FLAG_N};
      logic [4:0] s;
      for (int c = 0; c < 8; c++)
         for (int t = 0; t < 2; t++)
         begin
            s = 5'h00;
            s[pos[c / 2]] = t[0] ^ c[0];
            go({`BRANCH_HI5, 3'(c), 8'h80}, s);
            chk({opc, pcl}, {`OP_BRANCH, t[0]});
            if (t == 1)
               chk(tgt, 20'hFFF80);
            nxt(t[0]);
         end
   endtask
   task automatic t_skip;
      for (int n = 0; n < 4; n++)
      begin
         go({n[1] ? `NIB_SKIP_SET : `NIB_SKIP_CLEAR, 12'h620}, 5'h00, n[0] ? 8'h08 : 8'hF7);
         chk(opc, `OP_BIT_TEST);
         nxt(n[1] == n[0]);
      end
      go(16'hB620, 5'h00, 8'hF7);
      go(16'hEF12);
      chk(fl, 1'b1);
      go(16'hF345);
      chk({fl, pcl}, 2'h2);
      nxt(1'b0);
   endtask
   task automatic t_marks;
      go(16'h5220, 5'h00, 8'h00, 3'h4);
      chk({opc, pin, pclr}, {`OP_FILE, 2'h2});
      go(16'h5220, 5'h00, 8'h00, 3'h3);
      chk({pin, pclr}, 2'h1);
      go(16'h5220, 5'h00, 8'h00, 3'h2);
      chk(pclr, 1'b0);
      go(16'h5020, 5'h00, 8'h00, 3'h3);
      chk(pclr, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever
         #4 clk = ~clk;
   end
   initial
   begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_literal;
      t_ctrl;
      t_return;
      t_table;
      t_jump;
      t_branch;
      t_skip;
      t_marks;
      t_reset;
      print_verdict;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      err_total++;
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
